// [sdmi_pkg.sv]
// package: register map, field layout, reset values and timing constants
package sdmi_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] DRIVER_CONTROL_REG = 4'h0;
  localparam logic [3:0] CHOPPER_CONFIG_REG = 4'h1;
  localparam logic [3:0] CURRENT_SETTING_REG = 4'h2;
  localparam logic [3:0] STATUS_REG = 4'h3;
  // driver_control_reg fields
  localparam int DEDGE_BIT = 0;
  localparam int RES_LSB = 4;
  // chopper_config_reg fields
  localparam int INTERP_BIT = 0;
  // current_setting_reg fields
  localparam int HOLD_LSB = 0;
  localparam int RUN_LSB = 8;
  // status_reg fields
  localparam int STST_BIT = 0;
  localparam int POS_LSB = 16;
  // reset values
  localparam logic [3:0] RES_RST = 4'h4;
  localparam logic [4:0] HOLD_RST = 5'h05;
  localparam logic [4:0] RUN_RST = 5'h1F;
  // table size and microstep figures
  localparam int POS_W = 10;
  localparam int MAX_RES_SEL = 8;
  localparam logic [3:0] RES_16X = 4'h4;
  localparam int SUBSTEPS = 16;
  // longest measurable step period, 2^20 system clocks
  localparam int PERIOD_W = 20;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 20'hFFFFF;
endpackage : sdmi_pkg

// [sdmi_sync.sv]
// two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module sdmi_sync (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic d,
  output logic q
);
  logic meta;
  // first stage is read only by the second
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sdmi_sync

// [sdmi_period.sv]
// step period meter with saturation and standstill timeout
`timescale 1ns/1ps
module sdmi_period #(
  parameter int PW = sdmi_pkg::PERIOD_W
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic step_evt,
  output logic [PW-1:0] period,
  output logic timeout
);
  logic [PW-1:0] count;
  wire at_max = &count;
  // narrower meters leave nothing to split into sixteen
  if (PW < 8) begin : g_pw_check
    $error("period width too small");
  end
  // count clocks since last active edge; saturate at the cap
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      count <= '0;
      period <= '0;
      timeout <= 1'b0;
    end else if (step_evt) begin
      period <= count;
      count <= '0;
      timeout <= 1'b0;
    end else begin
      if (!at_max) count <= count + 1'b1; // [R13]
      timeout <= at_max; // [R14]
    end
  end
endmodule : sdmi_period

// [sdmi_top.sv]
// step/dir front end with microstep counter, interpolator and standstill
//
// Functional notes
// [R1] double-edge bit set: rising and falling step edges both count
// [R2] double-edge bit clear: only rising step edges count
// [R3] step and direction pass two flip-flops before edge detection
// [R4] sine table of 1024 entries indexed by the position counter
// [R5] direction 0 adds step width, direction 1 subtracts it
// [R6] resolution 0 gives width 1, each step up doubles, 4 is 16x
// [R7] resolution change applies to later steps, counter untouched
// [R8] half and full step positions lie every 128 table entries
// [R9] controller moves to symmetric position before lowering resolution
// [R10] interpolation yields 16 microsteps of 256x per active edge
// [R11] interpolation enable bit acts only at 16x resolution
// [R12] microstep spacing is the previous step period over 16
// [R13] measured step period saturates at 2^20 system clocks
// [R14] standstill flag sets when no edge within maximum period
// [R15] standstill selects hold current instead of run current
// [R16] standstill flag clears on the next active edge
// [R17] new period adopted after one cycle; leftovers dropped on new step
// [R18] controller uses 50% duty with double edge, stable rate interpolating
// [R19] separate run and hold currents, chosen by motion state
// [R20] position counter is 10 bits and wraps both ways
// [R21] without interpolation each edge moves the full width at once
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module sdmi_top #(
  parameter int PW = sdmi_pkg::PERIOD_W
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic STEP,
  input wire logic DIR,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic [9:0] POSITION,
  output logic [4:0] COIL_CURRENT,
  output logic STANDSTILL
);
  localparam int PS = sdmi_pkg::POS_W;

  // the 16 way split needs at least four bits above the divide
  if (PW < 8) begin : g_pw_check
    $error("step period width too small");
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic step_s;
  logic dir_s;
  sdmi_sync u_step_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .d(STEP),
    .q(step_s)
  ); // [R3]
  sdmi_sync u_dir_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .d(DIR),
    .q(dir_s)
  ); // [R3]

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic dedge;
  logic [3:0] resolution_select;
  logic interpolate_enable;
  logic [4:0] hold_current;
  logic [4:0] run_current;
  wire wr_drv = WR && (ADDR == sdmi_pkg::DRIVER_CONTROL_REG);
  wire wr_chop = WR && (ADDR == sdmi_pkg::CHOPPER_CONFIG_REG);
  wire wr_cur = WR && (ADDR == sdmi_pkg::CURRENT_SETTING_REG);

  // writes take effect next cycle; resolution alone never touches position
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dedge <= 1'b0;
      resolution_select <= sdmi_pkg::RES_RST;
      interpolate_enable <= 1'b0;
      hold_current <= sdmi_pkg::HOLD_RST;
      run_current <= sdmi_pkg::RUN_RST;
    end else begin
      if (wr_drv) begin
        dedge <= WDATA[sdmi_pkg::DEDGE_BIT];
        resolution_select <= WDATA[sdmi_pkg::RES_LSB +: 4]; // [R7]
      end
      if (wr_chop) interpolate_enable <= WDATA[sdmi_pkg::INTERP_BIT];
      if (wr_cur) begin
        hold_current <= WDATA[sdmi_pkg::HOLD_LSB +: 5]; // [R19]
        run_current <= WDATA[sdmi_pkg::RUN_LSB +: 5]; // [R19]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // active edge detection on the synchronised step level
  logic step_d;
  always_ff @(posedge CLK) begin
    if (SYS_RST) step_d <= 1'b0;
    else step_d <= step_s;
  end
  wire rise = step_s && !step_d;
  wire fall = !step_s && step_d;
  // rising always counts, falling only with double edge
  wire step_evt = rise || (dedge && fall); // [R1] [R2]

  //////////////////////////////////////////////////////////////////////////
  // step width: 1 << resolution, values above 8 behave as full step
  wire [3:0] res_eff = (resolution_select > 4'h8) ? 4'h8 : resolution_select;
  wire [PS-1:0] width = PS'(1) << res_eff; // [R6]
  // interpolation only when configured for 16x input
  wire interp_on = interpolate_enable
    && (resolution_select == sdmi_pkg::RES_16X); // [R11]

  //////////////////////////////////////////////////////////////////////////
  // period measurement and standstill timeout
  logic [PW-1:0] period;
  logic timeout;
  sdmi_period #(
    .PW(PW)
  ) u_period (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .step_evt(step_evt),
    .period(period),
    .timeout(timeout)
  ); // [R13]

  //////////////////////////////////////////////////////////////////////////
  // interpolator: spacing = previous period / 16, taken at each edge
  // the division is a plain shift, so up to 15 clocks of the period are
  // left over at the end of each burst; a pause nobody notices, traded
  // for a divider that costs nothing
  // a period under 16 clocks still gets a spacing of one clock
  logic [PW-5:0] spacing;
  logic [PW-5:0] tick;
  logic [4:0] remain;
  logic sub_dir;
  wire [PW-5:0] next_spacing = (period[PW-1:4] == '0) ? (PW-4)'(1)
    : period[PW-1:4]; // [R12]
  wire sub_fire = (remain != 5'h00) && (tick == '0);

  // a fresh edge restarts the burst, dropping any leftover microsteps
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      spacing <= '0;
      tick <= '0;
      remain <= 5'h00;
      sub_dir <= 1'b0;
    end else if (step_evt && interp_on) begin
      spacing <= next_spacing; // [R17]
      tick <= '0;
      remain <= 5'(sdmi_pkg::SUBSTEPS); // [R10] [R17]
      sub_dir <= dir_s;
    end else if (step_evt) begin
      remain <= 5'h00;
    end else if (sub_fire) begin
      remain <= remain - 5'h01;
      tick <= spacing - 1'b1;
    end else if (tick != '0) begin
      tick <= tick - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // microstep position counter, modulo 1024
  logic [PS-1:0] microstep_position;
  wire direct = step_evt && !interp_on;
  wire [PS-1:0] delta = direct ? width : PS'(1);
  wire move_dir = direct ? dir_s : sub_dir;
  wire move = direct || (sub_fire && !step_evt);
  wire [PS-1:0] next_position = move_dir ? microstep_position - delta
    : microstep_position + delta; // [R5] [R20]

  always_ff @(posedge CLK) begin
    if (SYS_RST) microstep_position <= '0;
    else if (move) microstep_position <= next_position; // [R21] [R4]
  end

  //////////////////////////////////////////////////////////////////////////
  // standstill flag; an edge wins over a timeout in the same cycle
  // the timeout stays high while the meter sits at its cap, so the flag
  // keeps being set for as long as the motor rests
  logic standstill;
  always_ff @(posedge CLK) begin
    if (SYS_RST) standstill <= 1'b0;
    else if (step_evt) standstill <= 1'b0; // [R16]
    else if (timeout) standstill <= 1'b1; // [R14]
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs and read port
  wire [31:0] rd_word =
    (ADDR == sdmi_pkg::DRIVER_CONTROL_REG) ?
      {24'h0, resolution_select, 3'h0, dedge} :
    (ADDR == sdmi_pkg::CHOPPER_CONFIG_REG) ? {31'h0, interpolate_enable} :
    (ADDR == sdmi_pkg::CURRENT_SETTING_REG) ?
      {19'h0, run_current, 3'h0, hold_current} :
    (ADDR == sdmi_pkg::STATUS_REG) ?
      {6'h0, microstep_position, 15'h0, standstill} : 32'h0;
  // hold current during standstill, run current otherwise
  wire [4:0] next_current = standstill ? hold_current : run_current; // [R15]

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h0;
      POSITION <= '0;
      COIL_CURRENT <= sdmi_pkg::RUN_RST;
      STANDSTILL <= 1'b0;
    end else begin
      RDATA <= RD ? rd_word : 32'h0;
      POSITION <= microstep_position; // [R8] table index for sine lookup
      COIL_CURRENT <= next_current; // [R19]
      STANDSTILL <= standstill;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  dir_add_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (direct && !dir_s) |=> microstep_position == $past(microstep_position)
      + $past(width)) else $error("forward step width wrong"); // [R5]
  dir_sub_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (direct && dir_s) |=> microstep_position == $past(microstep_position)
      - $past(width)) else $error("reverse step width wrong"); // [R5]
  single_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!dedge && fall) |-> !step_evt) else $error("falling edge taken"); // [R2]
  double_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (dedge && fall) |-> step_evt) else $error("falling edge lost"); // [R1]
  burst_load_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (step_evt && interp_on) |=> remain == 5'h10)
    else $error("burst not 16"); // [R10]
  stst_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    step_evt |=> ##1 !STANDSTILL) else $error("standstill kept"); // [R16]
  hold_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    standstill |=> COIL_CURRENT == $past(hold_current))
    else $error("hold current missing"); // [R15]
  res_keep_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wr_drv && !move) |=> $stable(microstep_position))
    else $error("resolution write moved position"); // [R7]

  // synchronisers: pin levels reach the edge logic two clocks later
  step_sync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    ##2 (step_s == $past(STEP, 2)))
    else $error("step pin not synchronised"); // [R3]
  dir_sync_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    ##2 (dir_s == $past(DIR, 2)))
    else $error("direction pin not synchronised"); // [R3]

  // edge selection and mode bit
  rise_taken_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    rise |-> step_evt) else $error("rising edge lost"); // [R2]
  dedge_load_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_drv |=> dedge == $past(WDATA[sdmi_pkg::DEDGE_BIT]))
    else $error("double edge bit not loaded"); // [R1]

  // step width per resolution code
  width_256_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (resolution_select == 4'h0) |-> width == 10'h001)
    else $error("256x width wrong"); // [R6]
  width_16_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (resolution_select == 4'h4) |-> width == 10'h010)
    else $error("16x width wrong"); // [R6]
  width_full_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (resolution_select >= 4'h8) |-> width == 10'h100)
    else $error("full step width wrong"); // [R6]

  // the counter wraps modulo 1024 going forward
  pos_wrap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (direct && !dir_s && microstep_position == 10'h3FF)
      |=> microstep_position == $past(width) - 10'h001)
    else $error("position did not wrap"); // [R20]
  pos_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!step_evt && remain == 5'h00) |=> $stable(microstep_position))
    else $error("position moved without a step"); // [R21]
  pos_out_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> POSITION == $past(microstep_position))
    else $error("table index output lags"); // [R8]

  // interpolation gating and burst behaviour
  interp_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (resolution_select != sdmi_pkg::RES_16X) |-> !interp_on)
    else $error("interpolation outside 16x"); // [R11]
  burst_wait_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (step_evt && interp_on) |=> $stable(microstep_position))
    else $error("interpolated edge moved at once"); // [R10]
  sub_fwd_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (sub_fire && !step_evt && !sub_dir)
      |=> microstep_position == $past(microstep_position) + 10'h001)
    else $error("forward microstep wrong"); // [R10] [R5]
  sub_back_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (sub_fire && !step_evt && sub_dir)
      |=> microstep_position == $past(microstep_position) - 10'h001)
    else $error("reverse microstep wrong"); // [R10] [R5]
  spacing_min_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (step_evt && interp_on) |=> spacing != '0)
    else $error("zero microstep spacing"); // [R12]
  drop_left_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (step_evt && !interp_on) |=> remain == 5'h00)
    else $error("leftover microsteps kept"); // [R17]

  // helper: microsteps since the last edge and clocks since the last one
  logic [4:0] burst_seen;
  logic [PW-5:0] gap_cnt;
  always_ff @(posedge CLK) begin
    if (SYS_RST || step_evt) begin
      burst_seen <= 5'h00;
      gap_cnt <= '0;
    end else if (sub_fire) begin
      burst_seen <= burst_seen + 5'h01;
      gap_cnt <= '0;
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end
  burst_count_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (sub_fire && !step_evt) |-> burst_seen < 5'h10)
    else $error("more than 16 microsteps"); // [R10]
  sub_gap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (sub_fire && !step_evt && burst_seen != 5'h00)
      |-> gap_cnt == spacing - 1'b1)
    else $error("microstep spacing uneven"); // [R12]

  // standstill flag, its output and the current choice
  stst_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (timeout && !step_evt) |=> standstill)
    else $error("standstill not flagged"); // [R14]
  stst_out_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    1'b1 |=> STANDSTILL == $past(standstill))
    else $error("standstill output lags"); // [R14]
  run_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !standstill |=> COIL_CURRENT == $past(run_current))
    else $error("run current missing"); // [R19]

  // read port: data only in the cycle after the strobe
  read_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !RD |=> RDATA == 32'h0) else $error("read data without strobe");
endmodule : sdmi_top

// [sdmi_stepgen.sv]
// step pin model standing in for the motion controller
`timescale 1ns/1ps
module sdmi_stepgen (
  input wire logic CLK,
  input wire logic fire,
  input wire logic dir_in,
  output logic step_o,
  output logic dir_o
);
  logic [2:0] wait_cnt;
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    wait_cnt = 3'h0;
  end
  // direction settles first so the pin edge never races it
  always @(posedge CLK) begin
    if (fire) begin
      dir_o <= dir_in;
      wait_cnt <= 3'h4;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
      // toggling keeps high and low equally long for double edge use
      if (wait_cnt == 3'h1) step_o <= ~step_o;
    end
  end
endmodule : sdmi_stepgen

// [test_step_dir_microstep_interpolator.sv]
// self-checking bench for the step/dir microstep front end
`timescale 1ns/1ps
module test_step_dir_microstep_interpolator;
  typedef struct packed {
    logic de;
    logic ip;
    logic [3:0] res;
    logic dir;
  } sdmi_row_s;
  logic CLK, SYS_RST, STEP, DIR, WR, RD, fire, dir_in, STANDSTILL;
  logic [3:0] ADDR;
  logic [31:0] WDATA, RDATA, rd_val;
  logic [9:0] POSITION, pos, base;
  logic [4:0] COIL_CURRENT;
  int n_fail, samples_checked;
  int cycles = 0;
  sdmi_row_s rows [13];
  // short period meter so the standstill timeout falls inside the run
  sdmi_top #(.PW(8)) uut (.CLK(CLK), .SYS_RST(SYS_RST), .STEP(STEP),
    .DIR(DIR),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .POSITION(POSITION), .COIL_CURRENT(COIL_CURRENT),
    .STANDSTILL(STANDSTILL));
  sdmi_stepgen ctrl (.CLK(CLK), .fire(fire), .dir_in(dir_in),
    .step_o(STEP), .dir_o(DIR));
  //////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rd_val = RDATA;
  endtask : rd
  task automatic step_edge(input logic d);
    @(posedge CLK);
    dir_in <= d;
    fire <= 1'b1;
    @(posedge CLK);
    fire <= 1'b0;
    repeat (12) @(posedge CLK);
    #1;
  endtask : step_edge
  function automatic logic [9:0] wid(input logic [3:0] r);
    return (r > 4'h8) ? 10'h100 : 10'h001 << r;
  endfunction : wid
  //////////////////////////////////////////////////////////////////////
  initial begin
    SYS_RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 32'h0;
    fire = 1'b0;
    dir_in = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    rows = '{'{0,0,4'h0,0}, '{0,0,4'h0,0}, '{1,0,4'h1,0}, '{1,0,4'h2,1},
      '{1,0,4'h3,0}, '{1,0,4'h4,1}, '{1,0,4'h5,0}, '{1,0,4'h6,1},
      '{1,0,4'h7,0}, '{1,0,4'h8,1}, '{1,0,4'hF,0}, '{1,1,4'h0,1},
      '{1,0,4'h4,1}};
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    #1 chk("position", 32'h0, 32'(POSITION));
    chk("current", 32'h1F, 32'(COIL_CURRENT));
    chk("standstill", 32'h0, 32'(STANDSTILL));
    rd(sdmi_pkg::DRIVER_CONTROL_REG);
    chk("ctrl", 32'h40, rd_val);
    rd(sdmi_pkg::CURRENT_SETTING_REG);
    chk("curset", 32'h1F05, rd_val);
    rd(4'hF);
    chk("unmapped", 32'h0, rd_val);
    // each row sets mode and resolution, then sends one pin edge
    pos = 10'h000;
    foreach (rows[i]) begin
      wr(sdmi_pkg::DRIVER_CONTROL_REG,
        (32'(rows[i].res) << sdmi_pkg::RES_LSB) | 32'(rows[i].de));
      wr(sdmi_pkg::CHOPPER_CONFIG_REG, 32'(rows[i].ip));
      #1 chk("kept", 32'(pos), 32'(POSITION));
      if (rows[i].de || !STEP)
        pos = rows[i].dir ? pos - wid(rows[i].res) : pos + wid(rows[i].res);
      step_edge(rows[i].dir);
      chk("moved", 32'(pos), 32'(POSITION));
    end
    rd(sdmi_pkg::STATUS_REG);
    chk("status", 32'(pos) << sdmi_pkg::POS_LSB, rd_val);
    wr(sdmi_pkg::CURRENT_SETTING_REG, 32'h1A05);
    repeat (2) @(posedge CLK);
    #1 chk("run current", 32'h1A, 32'(COIL_CURRENT));
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC);
    chk("unmapped", 32'h0, rd_val);
    // steady 16x edges so the meter learns a period of about 214 cycles
    // resolution stays at 16x here, so no symmetric stop is needed
    wr(sdmi_pkg::DRIVER_CONTROL_REG, 32'h41);
    wr(sdmi_pkg::CHOPPER_CONFIG_REG, 32'h1);
    repeat (3) begin
      step_edge(1'b0);
      repeat (200) @(posedge CLK);
    end
    #1 base = POSITION;
    step_edge(1'b0);
    chk("spread", 32'h1, 32'((POSITION - base) != 10'h0 &&
      (POSITION - base) < 10'h010));
    repeat (220) @(posedge CLK);
    #1 chk("interp", 32'(base + 10'h010), 32'(POSITION));
    // no edge for longer than the short meter cap: hold current takes over
    repeat (60) @(posedge CLK);
    #1 chk("standstill set", 32'h1, 32'(STANDSTILL));
    chk("hold current", 32'h05, 32'(COIL_CURRENT));
    rd(sdmi_pkg::STATUS_REG);
    chk("status stst", 32'h1, rd_val & 32'h1);
    step_edge(1'b0);
    chk("standstill clear", 32'h0, 32'(STANDSTILL));
    chk("run again", 32'h1A, 32'(COIL_CURRENT));
    tally_and_finish();
  end
endmodule : test_step_dir_microstep_interpolator
